// ===== include/sysctrl_irq_cfg.svh
// offsets, field positions, reset values and response codes of the interrupt-enable bank
`ifndef SYSCTRL_IRQ_CFG_SVH
`define SYSCTRL_IRQ_CFG_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define IEN_OFF_CLEAR      12'h000
`define IEN_OFF_SET        12'h004
`define IEN_OFF_EVT_STATUS 12'h008
`define IEN_OFF_EVT_MASK   12'h00c

// ----------------------------------------
// enable bit positions
// ----------------------------------------
`define IEN_BIT_CRYSTAL_HF_READY  0
`define IEN_BIT_CRYSTAL32K_READY  1
`define IEN_BIT_RC32K_READY       2
`define IEN_BIT_RC8M_READY        3
`define IEN_BIT_FLL_READY         4
`define IEN_BIT_FLL_OUT_OF_BOUNDS 5
`define IEN_BIT_FLL_FINE_LOCK     6
`define IEN_BIT_FLL_COARSE_LOCK   7
`define IEN_BIT_FLL_REF_STOPPED   8
`define IEN_BIT_BROWNOUT_READY    9
`define IEN_BIT_BROWNOUT_DETECT   10
`define IEN_BIT_BROWNOUT_SYNC_RDY 11
`define IEN_BIT_PLL_LOCK_RISE     15
`define IEN_BIT_PLL_LOCK_FALL     16
`define IEN_BIT_PLL_LOCK_TIMEOUT  17

// ----------------------------------------
// widths, masks and reset values
// ----------------------------------------
`define IEN_WIDTH        18
`define IEN_IMPL_MASK    18'h38fff
`define IEN_RESET        18'h00000
`define EVT_STATUS_RESET 18'h00000
`define EVT_MASK_RESET   18'h00000

// ----------------------------------------
// bus response codes
// ----------------------------------------
`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2
`define AXI_RESP_DECERR 2'h3

`endif

// ===== include/sysctrl_irq_pkg.sv
// types shared by the interrupt-enable bank
`include "sysctrl_irq_cfg.svh"
package sysctrl_irq_pkg;
  typedef logic [`IEN_WIDTH-1:0] ien_vec_t;
  typedef logic [1:0]            axi_resp_t;
  typedef enum logic [2:0] {
    SEL_CLEAR,
    SEL_SET,
    SEL_EVT_STATUS,
    SEL_EVT_MASK,
    SEL_NONE
  } reg_sel_e;
endpackage : sysctrl_irq_pkg

// ===== logic/sticky_bits.sv
// sticky event bits: rising edges of level inputs set, write-one clears
`timescale 1ns/1ps
module sticky_bits #(
  parameter int W = 18
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_level,
  input  wire logic [W-1:0] i_clear,
  output logic      [W-1:0] o_status
);
  logic [W-1:0] prev_q;
  logic [W-1:0] status_q;
  logic [W-1:0] status_d;
  wire  [W-1:0] rise = i_level & ~prev_q;

  // a rise in the clearing cycle wins, so no event is lost
  assign status_d = (status_q & ~i_clear) | rise;
  assign o_status = status_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_q   <= '0;
      status_q <= '0;
    end else begin
      prev_q   <= i_level;
      status_q <= status_d;
    end
  end
endmodule : sticky_bits

// ===== logic/axil_front.sv
// axi4-lite slave handshake: one write and one read in flight
`timescale 1ns/1ps
module axil_front #(
  parameter int AW = 12
) (
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  input  wire logic [AW-1:0] i_awaddr,
  input  wire logic          i_awvalid,
  output logic               o_awready,
  input  wire logic [31:0]   i_wdata,
  input  wire logic [3:0]    i_wstrb,
  input  wire logic          i_wvalid,
  output logic               o_wready,
  output logic [1:0]         o_bresp,
  output logic               o_bvalid,
  input  wire logic          i_bready,
  input  wire logic [AW-1:0] i_araddr,
  input  wire logic          i_arvalid,
  output logic               o_arready,
  output logic [31:0]        o_rdata,
  output logic [1:0]         o_rresp,
  output logic               o_rvalid,
  input  wire logic          i_rready,
  output logic               o_wr_fire,
  output logic [AW-1:0]      o_wr_addr,
  output logic [31:0]        o_wr_data,
  output logic [3:0]         o_wr_strb,
  input  wire logic [1:0]    i_wr_resp,
  output logic [AW-1:0]      o_rd_addr,
  input  wire logic [31:0]   i_rd_data,
  input  wire logic [1:0]    i_rd_resp
);
  logic aw_full_q;
  logic w_full_q;
  logic ar_full_q;
  wire  aw_take = i_awvalid & o_awready;
  wire  w_take  = i_wvalid & o_wready;
  wire  ar_take = i_arvalid & o_arready;
  wire  b_done  = o_bvalid & i_bready;
  wire  r_done  = o_rvalid & i_rready;

  // address and data may come in either order; fire once both are held
  assign o_wr_fire = aw_full_q & w_full_q & ~o_bvalid;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= `AXI_RESP_OKAY;
      o_wr_addr <= '0;
      o_wr_data <= 32'h0;
      o_wr_strb <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        o_awready <= 1'b0;
        o_wr_addr <= i_awaddr;
      end
      if (w_take) begin
        w_full_q  <= 1'b1;
        o_wready  <= 1'b0;
        o_wr_data <= i_wdata;
        o_wr_strb <= i_wstrb;
      end
      if (o_wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= i_wr_resp;
      end
      if (b_done) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ar_full_q <= 1'b0;
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0;
      o_rresp   <= `AXI_RESP_OKAY;
      o_rd_addr <= '0;
    end else begin
      if (ar_take) begin
        ar_full_q <= 1'b1;
        o_arready <= 1'b0;
        o_rd_addr <= i_araddr;
      end
      if (ar_full_q) begin
        ar_full_q <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rdata   <= i_rd_data;
        o_rresp   <= i_rd_resp;
      end
      if (r_done) begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
endmodule : axil_front

// ===== logic/sysctrl_irq_enable.sv
// interrupt-enable clear/set register bank of the clock and supply controller
`timescale 1ns/1ps
// How it works
// - the bus takes single byte, halfword and word accesses to the 32-bit registers.
// - every byte lane and halfword of a register can be written and read on its own.
// - while the access guard unit protects the bank, enable writes are blocked.
// - a one written to an implemented bit of the clear register drops that enable.
// - a zero written to the clear register leaves the enable as it was.
// - set and clear registers share one enable vector and both read it back.
// - a source requests an interrupt on o_irq_req only in the cycle after its enable and its flag were both one.
// - bits 31:18 and 14:12 are read-only and read zero.
// - bit 0 gates crystal ready, bits 1 to 3 the 32k crystal, 32k rc and 8m rc ready.
// - bits 4 to 8 gate fll ready, out of bounds, fine lock, coarse lock, ref stopped.
// - bits 9 to 11 gate brown-out ready, detection and sync ready.
// - bits 15 to 17 gate pll lock rise, lock fall and lock timeout.
// - a one written to the set register at offset 0x04 raises that enable.
`include "sysctrl_irq_cfg.svh"
module sysctrl_irq_enable #(
  parameter int AW = 12
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rstn,
  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  input  wire logic [AW-1:0]         i_awaddr,
  input  wire logic [2:0]            i_awprot,
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  output logic [1:0]                 o_bresp,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  input  wire logic [AW-1:0]         i_araddr,
  input  wire logic [2:0]            i_arprot,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  // ----------------------------------------
  // protection and interrupt sources
  // ----------------------------------------
  input  wire logic                  i_write_protect,
  input  wire logic [`IEN_WIDTH-1:0] i_irq_flag,
  // ----------------------------------------
  // interrupt outputs
  // ----------------------------------------
  output logic [`IEN_WIDTH-1:0]      o_irq_req,
  output logic                       o_irq,
  output logic                       o_evt_irq
);

  // ----------------------------------------
  // bus front end
  // ----------------------------------------
  logic                wr_fire;
  logic [AW-1:0]       wr_addr;
  logic [31:0]         wr_data;
  logic [3:0]          wr_strb;
  logic [AW-1:0]       rd_addr;
  sysctrl_irq_pkg::axi_resp_t wr_resp;
  sysctrl_irq_pkg::axi_resp_t rd_resp;
  logic [31:0]         rd_data;

  // prot carries no meaning here; the access guard unit decides protection
  axil_front #(
    .AW (AW)
  ) u_front (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr_fire (wr_fire),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_resp (wr_resp),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_resp (rd_resp)
  );

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // low two address bits are ignored: lanes are chosen by the strobes
  wire [AW-1:0] wr_word = {wr_addr[AW-1:2], 2'b00};
  wire [AW-1:0] rd_word = {rd_addr[AW-1:2], 2'b00};

  sysctrl_irq_pkg::reg_sel_e wr_sel;
  sysctrl_irq_pkg::reg_sel_e rd_sel;

  assign wr_sel =
    (wr_word == AW'(`IEN_OFF_CLEAR))      ? sysctrl_irq_pkg::SEL_CLEAR      :
    (wr_word == AW'(`IEN_OFF_SET))        ? sysctrl_irq_pkg::SEL_SET        :
    (wr_word == AW'(`IEN_OFF_EVT_STATUS)) ? sysctrl_irq_pkg::SEL_EVT_STATUS :
    (wr_word == AW'(`IEN_OFF_EVT_MASK))   ? sysctrl_irq_pkg::SEL_EVT_MASK   :
                                            sysctrl_irq_pkg::SEL_NONE;

  assign rd_sel =
    (rd_word == AW'(`IEN_OFF_CLEAR))      ? sysctrl_irq_pkg::SEL_CLEAR      :
    (rd_word == AW'(`IEN_OFF_SET))        ? sysctrl_irq_pkg::SEL_SET        :
    (rd_word == AW'(`IEN_OFF_EVT_STATUS)) ? sysctrl_irq_pkg::SEL_EVT_STATUS :
    (rd_word == AW'(`IEN_OFF_EVT_MASK))   ? sysctrl_irq_pkg::SEL_EVT_MASK   :
                                            sysctrl_irq_pkg::SEL_NONE;

  // ----------------------------------------
  // byte lanes
  // ----------------------------------------
  // one strobe per byte gives byte, halfword and word writes alike
  wire [31:0] lane_mask = {{8{wr_strb[3]}},
                           {8{wr_strb[2]}},
                           {8{wr_strb[1]}},
                           {8{wr_strb[0]}}};

  // reserved bits are dropped before they reach any register
  wire [`IEN_WIDTH-1:0] wr_bits =
    wr_data[`IEN_WIDTH-1:0] & lane_mask[`IEN_WIDTH-1:0] & `IEN_IMPL_MASK;

  // ----------------------------------------
  // write qualification
  // ----------------------------------------
  wire enable_target = (wr_sel == sysctrl_irq_pkg::SEL_CLEAR) ||
                       (wr_sel == sysctrl_irq_pkg::SEL_SET);
  wire blocked       = enable_target & i_write_protect;

  wire do_clear  = wr_fire & (wr_sel == sysctrl_irq_pkg::SEL_CLEAR) & ~i_write_protect;
  wire do_set    = wr_fire & (wr_sel == sysctrl_irq_pkg::SEL_SET) & ~i_write_protect;
  wire do_status = wr_fire & (wr_sel == sysctrl_irq_pkg::SEL_EVT_STATUS);
  wire do_mask   = wr_fire & (wr_sel == sysctrl_irq_pkg::SEL_EVT_MASK);

  // a refused write is answered with an error so software can see it
  assign wr_resp = (wr_sel == sysctrl_irq_pkg::SEL_NONE) ? `AXI_RESP_DECERR :
                   blocked                               ? `AXI_RESP_SLVERR :
                                                           `AXI_RESP_OKAY;

  // ----------------------------------------
  // shared enable vector
  // ----------------------------------------
  // one vector behind both addresses keeps set and clear coherent
  logic [`IEN_WIDTH-1:0] ien_q;                                             
  logic [`IEN_WIDTH-1:0] ien_d;

  wire [`IEN_WIDTH-1:0] clr_bits = do_clear ? wr_bits : '0;
  wire [`IEN_WIDTH-1:0] set_bits = do_set   ? wr_bits : '0;

  assign ien_d = (ien_q & ~clr_bits) | set_bits;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ien_q <= `IEN_RESET;
    end else begin
      ien_q <= ien_d;
    end
  end

  // ----------------------------------------
  // named enables
  // ----------------------------------------
  wire crystal_hf_ready_ie     = ien_q[`IEN_BIT_CRYSTAL_HF_READY];
  wire crystal32k_ready_ie     = ien_q[`IEN_BIT_CRYSTAL32K_READY];
  wire rc32k_ready_ie          = ien_q[`IEN_BIT_RC32K_READY];
  wire rc8m_ready_ie           = ien_q[`IEN_BIT_RC8M_READY];
  wire fll_ready_ie            = ien_q[`IEN_BIT_FLL_READY];
  wire fll_out_of_bounds_ie    = ien_q[`IEN_BIT_FLL_OUT_OF_BOUNDS];
  wire fll_fine_lock_ie        = ien_q[`IEN_BIT_FLL_FINE_LOCK];
  wire fll_coarse_lock_ie      = ien_q[`IEN_BIT_FLL_COARSE_LOCK];
  wire fll_ref_stopped_ie      = ien_q[`IEN_BIT_FLL_REF_STOPPED];
  wire brownout_ready_ie       = ien_q[`IEN_BIT_BROWNOUT_READY];
  wire brownout_detect_ie      = ien_q[`IEN_BIT_BROWNOUT_DETECT];
  wire brownout_sync_ready_ie  = ien_q[`IEN_BIT_BROWNOUT_SYNC_RDY];
  wire pll_lock_rise_ie        = ien_q[`IEN_BIT_PLL_LOCK_RISE];
  wire pll_lock_fall_ie        = ien_q[`IEN_BIT_PLL_LOCK_FALL];
  wire pll_lock_timeout_ie     = ien_q[`IEN_BIT_PLL_LOCK_TIMEOUT];

  // reassembled in bit order; reserved middle bits stay zero
  wire [`IEN_WIDTH-1:0] gate_vec = {pll_lock_timeout_ie,
                                    pll_lock_fall_ie,
                                    pll_lock_rise_ie,
                                    3'b000,
                                    brownout_sync_ready_ie,
                                    brownout_detect_ie,
                                    brownout_ready_ie,
                                    fll_ref_stopped_ie,
                                    fll_coarse_lock_ie,
                                    fll_fine_lock_ie,
                                    fll_out_of_bounds_ie,
                                    fll_ready_ie,
                                    rc8m_ready_ie,
                                    rc32k_ready_ie,
                                    crystal32k_ready_ie,
                                    crystal_hf_ready_ie};

  // ----------------------------------------
  // event status and mask
  // ----------------------------------------
  logic [`IEN_WIDTH-1:0] evt_status;
  logic [`IEN_WIDTH-1:0] evt_mask_q;

  wire [`IEN_WIDTH-1:0] evt_clear = do_status ? wr_bits : '0;

  sticky_bits #(
    .W (`IEN_WIDTH)
  ) u_events (
    .i_clk    (i_clk),
    .i_rstn   (i_rstn),
    .i_level  (i_irq_flag & `IEN_IMPL_MASK),
    .i_clear  (evt_clear),
    .o_status (evt_status)
  );

  // lanes that were not strobed keep their old mask bits
  wire [`IEN_WIDTH-1:0] mask_lanes = lane_mask[`IEN_WIDTH-1:0] & `IEN_IMPL_MASK;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      evt_mask_q <= `EVT_MASK_RESET;
    end else if (do_mask) begin
      evt_mask_q <= (evt_mask_q & ~mask_lanes) | wr_bits;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [`IEN_WIDTH-1:0] rd_bits;

  assign rd_bits =
    ((rd_sel == sysctrl_irq_pkg::SEL_CLEAR) ||
     (rd_sel == sysctrl_irq_pkg::SEL_SET))     ? ien_q      :
    (rd_sel == sysctrl_irq_pkg::SEL_EVT_STATUS) ? evt_status :
    (rd_sel == sysctrl_irq_pkg::SEL_EVT_MASK)   ? evt_mask_q :
                                                  '0;

  // the full word is returned; the master picks the lanes it asked for
  assign rd_data = {{(32-`IEN_WIDTH){1'b0}}, rd_bits & `IEN_IMPL_MASK};

  assign rd_resp = (rd_sel == sysctrl_irq_pkg::SEL_NONE) ? `AXI_RESP_DECERR :
                                                           `AXI_RESP_OKAY;

  // ----------------------------------------
  // interrupt requests
  // ----------------------------------------
  // registered outputs cost one cycle of latency on every request
  wire [`IEN_WIDTH-1:0] req_d   = gate_vec & i_irq_flag;
  wire                  irq_d   = |req_d;
  wire                  evt_d   = |(evt_status & evt_mask_q);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_req <= '0;
      o_irq     <= 1'b0;
      o_evt_irq <= 1'b0;
    end else begin
      o_irq_req <= req_d;
      o_irq     <= irq_d;
      o_evt_irq <= evt_d;
    end
  end

endmodule : sysctrl_irq_enable

// ===== testbench/sysctrl_irq_enable_properties.sv
// port-level assertions for the interrupt-enable bank
`timescale 1ns/1ps
`include "sysctrl_irq_cfg.svh"
module sysctrl_irq_enable_checker #(
  parameter int AW = 12
) (
  input wire logic                  i_clk,
  input wire logic                  i_rstn,
  input wire logic [AW-1:0]         i_awaddr,
  input wire logic                  i_awvalid,
  input wire logic                  o_awready,
  input wire logic                  i_wvalid,
  input wire logic                  o_wready,
  input wire logic [1:0]            o_bresp,
  input wire logic                  o_bvalid,
  input wire logic                  i_bready,
  input wire logic [AW-1:0]         i_araddr,
  input wire logic                  i_arvalid,
  input wire logic                  o_arready,
  input wire logic [31:0]           o_rdata,
  input wire logic [1:0]            o_rresp,
  input wire logic                  o_rvalid,
  input wire logic                  i_rready,
  input wire logic                  i_write_protect,
  input wire logic [`IEN_WIDTH-1:0] i_irq_flag,
  input wire logic [`IEN_WIDTH-1:0] o_irq_req,
  input wire logic                  o_irq
);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  // guard must still be up at the firing edge after the take
  sequence s_guarded_wr;
    s_wr_take ##0 (i_write_protect && i_awaddr[AW-1:3] == '0) ##1 i_write_protect;
  endsequence
  property p_req_flag;
    (o_irq_req & ~$past(i_irq_flag)) == '0;
  endproperty
  property p_irq_or;
    o_irq == (|o_irq_req);
  endproperty
  property p_rsvd_zero;
    o_rvalid |-> o_rdata[31:18] == '0 && o_rdata[14:12] == '0;
  endproperty
  property p_b_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  property p_wr_answer;
    s_wr_take |-> ##[1:2] o_bvalid;
  endproperty
  property p_guarded;
    s_guarded_wr |-> ##[0:1] (o_bvalid && o_bresp == `AXI_RESP_SLVERR);
  endproperty
  property p_rd_unmapped;
    i_arvalid && o_arready && i_araddr[AW-1:2] > 3 |-> ##[1:2] (o_rvalid && o_rresp == `AXI_RESP_DECERR);
  endproperty
  a_req_flag: assert property (p_req_flag) else $error("request without flag");
  a_irq_or: assert property (p_irq_or) else $error("irq line not or of requests");
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read data not zero");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  a_guarded: assert property (p_guarded) else $error("guarded write not refused");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
endmodule : sysctrl_irq_enable_checker

bind sysctrl_irq_enable sysctrl_irq_enable_checker #(.AW(AW)) i_checker (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
  .i_rready(i_rready), .i_write_protect(i_write_protect), .i_irq_flag(i_irq_flag),
  .o_irq_req(o_irq_req), .o_irq(o_irq)
);

// ===== testbench/sysctrl_irq_enable_tb.sv
// self-checking bench for the interrupt-enable bank
`timescale 1ns/1ps
`include "sysctrl_irq_cfg.svh"
module sysctrl_irq_enable_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [11:0] CLR = `IEN_OFF_CLEAR, SET = `IEN_OFF_SET;
  localparam logic [1:0]  OK = `AXI_RESP_OKAY;
  localparam logic [31:0] IMPL = 32'h0003_8fff;  // bits 17:15 and 11:0
  logic        i_clk, i_rstn = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        protect = 1'b0, awready, wready, bvalid, arready, rvalid, irq, evt_irq;
  logic [31:0] wdata = '0, rdata, en_q;
  logic [3:0]  wstrb = '0;
  logic [17:0] flag = '0, irq_req;
  logic [1:0]  bresp, rresp;
  int          bad_count = 0, samples_checked = 0, cycles = 0;

  sysctrl_irq_enable #(.AW(12)) i_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_awaddr(awaddr), .i_awprot(3'h0), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arprot(3'h0),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_write_protect(protect), .i_irq_flag(flag), .o_irq_req(irq_req),
    .o_irq(irq), .o_evt_irq(evt_irq)
  );

  // ----------------------------------------
  // clock, timeout and report
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("[FAIL] %0t ns: run hung", $time);
      end_of_test();
    end
  end
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: response %h expected %h", $time, got, exp);
    end
  endtask : check_resp

  // ----------------------------------------
  // bus tasks: stall holds the ready back for that many cycles
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] exp, input int stall);
    int n;
    n = 0;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (stall == 0);
    forever begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) break;
      n++;
      if (n >= stall) bready <= 1'b1;
    end
    bready <= 1'b0;
    check_resp(bresp, exp);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] exp_resp,
                    input int stall);
    int n;
    n = 0;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (stall == 0);
    forever begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) break;
      n++;
      if (n >= stall) rready <= 1'b1;
    end
    rready <= 1'b0;
    check_word(rdata, exp);
    check_resp(rresp, exp_resp);
  endtask : rd
  // requests lag an enable or flag change by one edge; two edges leave margin
  task automatic check_irq(input logic [31:0] exp_req);
    repeat (2) @(posedge i_clk);
    check_word({14'h0, irq_req}, exp_req);
    check_word({31'h0, irq}, {31'h0, |exp_req});
  endtask : check_irq

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(CLR, 32'h0, OK, 0);
    rd(SET, 32'h0, OK, 2);
    $display("reset values done");
    flag <= 18'h3ffff;
    en_q = 32'h0;
    for (int b = 0; b < 18; b++) begin
      wr(SET, 32'h1 << b, 4'hf, OK, b % 4);
      en_q = en_q | ((32'h1 << b) & IMPL);
      rd(CLR, en_q, OK, b % 4);
    end
    wr(SET, 32'hffff_ffff, 4'hf, OK, 0);
    rd(SET, IMPL, OK, 0);
    check_irq(IMPL);
    $display("enable set done");
    for (int b = 0; b < 18; b++) begin
      flag <= 18'h1 << b;
      check_irq(en_q & (32'h1 << b));
      wr(CLR, 32'h1 << b, 4'hf, OK, 1);
      en_q = en_q & ~(32'h1 << b);
      rd(SET, en_q, OK, 0);
      check_irq(32'h0);
    end
    $display("enable clear done");
    wr(SET, 32'hffff_ffff, 4'h2, OK, 0);
    wr(SET, 32'hffff_ffff, 4'hc, OK, 0);
    wr(CLR, 32'h0, 4'hf, OK, 0);
    wr(CLR, 32'hffff_ffff, 4'h1, OK, 0);
    rd(CLR, 32'h0003_8f00, OK, 0);
    wr(CLR, 32'h0000_0300, 4'h2, OK, 0);
    wr(CLR, 32'hffff_ffff, 4'h4, OK, 0);
    rd(SET, 32'h0000_8c00, OK, 0);
    $display("byte lanes done");
    protect <= 1'b1;
    wr(CLR, 32'hffff_ffff, 4'hf, `AXI_RESP_SLVERR, 0);
    wr(SET, 32'h0000_00ff, 4'hf, `AXI_RESP_SLVERR, 0);
    rd(CLR, 32'h0000_8c00, OK, 0);
    protect <= 1'b0;
    wr(12'h010, 32'hffff_ffff, 4'hf, `AXI_RESP_DECERR, 0);
    rd(12'hffc, 32'h0, `AXI_RESP_DECERR, 1);
    $display("guard and unmapped done");
    wr(`IEN_OFF_EVT_STATUS, 32'hffff_ffff, 4'hf, OK, 0);
    rd(`IEN_OFF_EVT_STATUS, 32'h0, OK, 0);
    flag <= 18'h0;
    wr(`IEN_OFF_EVT_MASK, 32'h8, 4'hf, OK, 0);
    rd(`IEN_OFF_EVT_MASK, 32'h8, OK, 0);
    flag <= 18'h8;
    rd(`IEN_OFF_EVT_STATUS, 32'h8, OK, 0);
    check_word({31'h0, evt_irq}, 32'h1);
    wr(`IEN_OFF_EVT_STATUS, 32'h8, 4'hf, OK, 0);
    repeat (2) @(posedge i_clk);
    check_word({31'h0, evt_irq}, 32'h0);
    $display("event status done");
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(CLR, 32'h0, OK, 0);
    $display("second reset done");
    end_of_test();
  end
endmodule : sysctrl_irq_enable_tb
